// ===== cfm_pkg.sv
// Constants, types and decode for the acceptance filter and buffer control.
// Assumes a 40 MHz system clock and AXI4-Lite register access.
// Behaviour
// RL1: Each standard mask bit set includes its identifier bit; clear ignores it.
// RL2: Each of eighteen extended mask bits includes its identifier bit when set.
// RL3: Type-match set: filter accepts only frames whose format equals its extended select.
// RL4: Type-match clear: either format accepted when masked identifier bits equal filter.
// RL5: Extended select picks extended or standard frames, only while type-match set.
// RL6: Four-bit buffer pointer: 1111 steers hits to FIFO, others to that buffer.
// RL7: Two-bit mask source selects mask 0, 1 or 2; code 11 reserved.
// RL8: Device sets a buffer full flag when it writes a received frame there.
// RL9: Software clears full flag by writing zero; writing one leaves flags unchanged.
// RL10: Storing into a still full buffer sets its overflow flag; zero write clears.
// RL11: Each control word serves two buffers: upper byte odd, lower byte even.
// RL12: Direction bit makes buffer transmit when set, receive when clear.
// RL13: Software sets send request; device clears it after successful transmission.
// RL14: Clearing a set send request asks for abort; outcome shown in abort status.
// RL15: Abort status reads one when aborted, zero when sent successfully.
// RL16: Arbitration loss status set when the frame lost bus arbitration.
// RL17: Transmit error status set when a bus error occurred during sending.
// RL18: Setting send request clears abort, arbitration loss and error status.
// RL19: Auto-remote enabled: matching remote frame sets that buffer's send request.
// RL20: Priority field: 11 highest, 10, 01, 00 lowest.
// RL21: Highest priority pending frame goes first; ties go to lowest buffer number.
package cfm_pkg;
  localparam int CFM_NF = 16;
  localparam int CFM_NB = 8;
  localparam int CFM_AW = 8;

  localparam logic [7:0] CFM_OFS_MSID = 8'h00;
  localparam logic [7:0] CFM_OFS_MEID = 8'h0c;
  localparam logic [7:0] CFM_OFS_FULL = 8'h18;
  localparam logic [7:0] CFM_OFS_OVF  = 8'h20;
  localparam logic [7:0] CFM_OFS_BCON = 8'h28;
  localparam logic [7:0] CFM_OFS_FSEL = 8'h38;
  localparam logic [7:0] CFM_OFS_BPTR = 8'h40;
  localparam logic [7:0] CFM_OFS_END  = 8'h50;

  localparam int CFM_SID_LSB = 5;
  localparam int CFM_MASK_ID_TYPE_MATCH    = 3;
  localparam logic [15:0] CFM_MSID_WMASK = 16'hffeb;
  localparam int CFM_DIR = 7;
  localparam int CFM_ABT = 6;
  localparam int CFM_LRB = 5;
  localparam int CFM_ERR = 4;
  localparam int CFM_REQ = 3;
  localparam int CFM_RTR = 2;
  localparam int CFM_PRI = 0;
  localparam logic [7:0] CFM_BCON_WMASK = 8'h8f;
  localparam logic [3:0] CFM_PTR_FIFO = 4'hf;
  localparam logic [1:0] CFM_MSK_RSVD = 2'h3;
  localparam logic [1:0] CFM_OKAY   = 2'h0;
  localparam logic [1:0] CFM_DECERR = 2'h3;

  typedef enum logic [2:0] {
    CFM_K_NONE = 3'h0, CFM_K_MSID = 3'h1, CFM_K_MEID = 3'h3, CFM_K_FULL = 3'h2,
    CFM_K_OVF  = 3'h6, CFM_K_BCON = 3'h7, CFM_K_FSEL = 3'h5, CFM_K_BPTR = 3'h4
  } cfm_kind_t;

  typedef enum logic [1:0] {
    CFM_TX_SENT = 2'h0, CFM_TX_ABORTED = 2'h1, CFM_TX_LOST = 2'h3, CFM_TX_BUSERR = 2'h2
  } cfm_txk_t;

  typedef struct packed {
    cfm_kind_t  kind;
    logic [1:0] idx;
  } cfm_dec_t;

  typedef struct packed {
    logic [10:0] std_id_bits;
    logic        ext_sel;
    logic [17:0] ext_id_bits;
  } cfm_filt_id_t;

  typedef struct packed {
    logic        valid;
    logic        ide;
    logic        rtr;
    logic [10:0] std_id_bits;
    logic [17:0] ext_id_bits;
  } cfm_frame_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] filter;
    logic [3:0] ptr;
    logic       fifo;
    logic       store;
  } cfm_rx_hit_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] buf_num;
  } cfm_fifo_wr_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] buf_num;
    cfm_txk_t   kind;
  } cfm_tx_evt_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] buf_num;
  } cfm_tx_pick_t;

  typedef struct packed {
    logic [2:0][15:0] msid;
    logic [2:0][15:0] meid;
    logic [31:0]      full;
    logic [31:0]      ovf;
    logic [7:0][7:0]  bcon;
    logic [7:0]       apend;
    logic [31:0]      fsel;
    logic [63:0]      bptr;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    cfm_rx_hit_t      hit;
    cfm_tx_pick_t     pick;
  } cfm_st_t;

  localparam cfm_st_t CFM_ST_RST = '0;

  function automatic cfm_dec_t cfm_dec(input logic [CFM_AW-1:0] a);
    cfm_dec_t   d;
    logic [7:0] o;
    d.kind = CFM_K_NONE;
    d.idx  = 2'h0;
    o      = 8'h00;
    if (a >= CFM_OFS_END) begin
      d.kind = CFM_K_NONE;
    end else if (a >= CFM_OFS_BPTR) begin
      d.kind = CFM_K_BPTR;
      o      = a - CFM_OFS_BPTR;
    end else if (a >= CFM_OFS_FSEL) begin
      d.kind = CFM_K_FSEL;
      o      = a - CFM_OFS_FSEL;
    end else if (a >= CFM_OFS_BCON) begin
      d.kind = CFM_K_BCON;
      o      = a - CFM_OFS_BCON;
    end else if (a >= CFM_OFS_OVF) begin
      d.kind = CFM_K_OVF;
      o      = a - CFM_OFS_OVF;
    end else if (a >= CFM_OFS_FULL) begin
      d.kind = CFM_K_FULL;
      o      = a - CFM_OFS_FULL;
    end else if (a >= CFM_OFS_MEID) begin
      d.kind = CFM_K_MEID;
      o      = a - CFM_OFS_MEID;
    end else begin
      d.kind = CFM_K_MSID;
      o      = a - CFM_OFS_MSID;
    end
    d.idx = o[3:2];
    return d;
  endfunction
endpackage

// ===== cfm_filter_ctrl.sv
// Acceptance filtering, receive full/overflow flags and transmit buffer control.
// Assumes filter identifiers, frame fields and transmit outcomes come from the CAN engine.
//
// Chosen here: the AXI4-Lite register port and the register offsets.
module cfm_filter_ctrl
  import cfm_pkg::*;
(
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  input  wire logic [CFM_AW-1:0]            s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [CFM_AW-1:0]            s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire cfm_filt_id_t [CFM_NF-1:0]    filt_id,
  input  wire cfm_frame_t                   rx_frame,
  input  wire cfm_fifo_wr_t                 rx_fifo_wr,
  input  wire cfm_tx_evt_t                  tx_evt,
  output cfm_rx_hit_t                       rx_hit,
  output cfm_tx_pick_t                      tx_pick,
  output logic [CFM_NB-1:0]                 tx_abort_pend
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] rst_q;
  logic       srst_n;
  cfm_st_t    s;
  cfm_st_t    next_s;

  // One identifier compare under a mask pair
  function automatic logic cfm_match(
    input cfm_filt_id_t f,
    input logic [15:0]  ms,
    input logic [15:0]  me,
    input cfm_frame_t   fr
  );
    logic [10:0] msid;
    logic [17:0] meid;
    logic        std_ok;
    logic        ext_ok;
    logic        ok;
    msid   = ms[15:CFM_SID_LSB];
    meid   = {ms[1:0], me};
    std_ok = ((f.std_id_bits ^ fr.std_id_bits) & msid) == 11'h000; // RL1
    ext_ok = std_ok && (((f.ext_id_bits ^ fr.ext_id_bits) & meid) == 18'h00000); // RL2
    ok     = fr.ide ? ext_ok : std_ok; // RL4
    if (ms[CFM_MASK_ID_TYPE_MATCH] && (fr.ide != f.ext_sel)) begin
      ok = 1'b0; // RL3 RL5
    end
    return ok;
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign srst_n = rst_q[1];

  always_comb begin
    cfm_dec_t    wd;
    cfm_dec_t    rd;
    logic [15:0] be;
    logic [15:0] wv;
    logic [15:0] rv;
    logic [2:0]  b;
    logic [7:0]  wb;
    logic [7:0]  old;
    logic [1:0]  msel;
    logic        hit;
    logic [3:0]  hitf;
    logic [3:0]  ptr;
    logic [4:0]  sb;
    logic        do_store;
    logic [1:0]  bpri;
    wd       = '0;
    rd       = '0;
    be       = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    wv       = s_axi_wdata[15:0];
    rv       = 16'h0000;
    b        = 3'h0;
    wb       = 8'h00;
    old      = 8'h00;
    msel     = 2'h0;
    hit      = 1'b0;
    hitf     = 4'h0;
    ptr      = 4'h0;
    sb       = 5'h00;
    do_store = 1'b0;
    bpri     = 2'h0;
    next_s   = s;
    next_s.hit = '0;
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end

    // Register writes
    if (s_axi_awvalid && s_axi_wvalid && !s.bvalid) begin
      wd            = cfm_dec(s_axi_awaddr);
      next_s.bvalid = 1'b1;
      next_s.bresp  = (wd.kind == CFM_K_NONE) ? CFM_DECERR : CFM_OKAY;
      unique case (wd.kind)
        CFM_K_MSID: begin
          next_s.msid[wd.idx] = (s.msid[wd.idx] & ~be) | (wv & be & CFM_MSID_WMASK);
        end
        CFM_K_MEID: begin
          next_s.meid[wd.idx] = (s.meid[wd.idx] & ~be) | (wv & be);
        end
        CFM_K_FULL: begin
          next_s.full[wd.idx[0]*16 +: 16] = s.full[wd.idx[0]*16 +: 16] & (wv | ~be); // RL9
        end
        CFM_K_OVF: begin
          next_s.ovf[wd.idx[0]*16 +: 16] = s.ovf[wd.idx[0]*16 +: 16] & (wv | ~be); // RL9 RL10
        end
        CFM_K_FSEL: begin
          next_s.fsel[wd.idx[0]*16 +: 16] = (s.fsel[wd.idx[0]*16 +: 16] & ~be) | (wv & be);
        end
        CFM_K_BPTR: begin
          next_s.bptr[wd.idx*16 +: 16] = (s.bptr[wd.idx*16 +: 16] & ~be) | (wv & be);
        end
        CFM_K_BCON: begin
          for (int h = 0; h < 2; h++) begin
            if (s_axi_wstrb[h]) begin
              b   = {wd.idx, h[0]}; // RL11
              wb  = s_axi_wdata[8*h +: 8];
              old = s.bcon[b];
              next_s.bcon[b] = (old & ~CFM_BCON_WMASK) | (wb & CFM_BCON_WMASK); // RL12 RL20
              if (wb[CFM_REQ] && !old[CFM_REQ]) begin
                next_s.bcon[b][CFM_ABT:CFM_ERR] = 3'h0; // RL13 RL18
                next_s.apend[b] = 1'b0;
              end else if (!wb[CFM_REQ] && old[CFM_REQ]) begin
                next_s.apend[b] = 1'b1; // RL14
              end
            end
          end
        end
        CFM_K_NONE: begin
        end
      endcase
    end

    // Register reads
    if (s_axi_arvalid && !s.rvalid) begin
      rd            = cfm_dec(s_axi_araddr);
      next_s.rvalid = 1'b1;
      next_s.rresp  = (rd.kind == CFM_K_NONE) ? CFM_DECERR : CFM_OKAY;
      unique case (rd.kind)
        CFM_K_MSID: rv = s.msid[rd.idx];
        CFM_K_MEID: rv = s.meid[rd.idx];
        CFM_K_FULL: rv = s.full[rd.idx[0]*16 +: 16];
        CFM_K_OVF:  rv = s.ovf[rd.idx[0]*16 +: 16];
        CFM_K_FSEL: rv = s.fsel[rd.idx[0]*16 +: 16];
        CFM_K_BPTR: rv = s.bptr[rd.idx*16 +: 16];
        CFM_K_BCON: rv = {s.bcon[{rd.idx, 1'b1}], s.bcon[{rd.idx, 1'b0}]}; // RL11
        CFM_K_NONE: rv = 16'h0000;
      endcase
      next_s.rdata = {16'h0000, rv};
    end

    // Transmit outcome from the engine
    if (tx_evt.valid) begin
      b = tx_evt.buf_num;
      unique case (tx_evt.kind)
        CFM_TX_SENT: begin
          next_s.bcon[b][CFM_REQ] = 1'b0; // RL13
          next_s.bcon[b][CFM_ABT] = 1'b0; // RL15
          next_s.apend[b]         = 1'b0;
        end
        CFM_TX_ABORTED: begin
          next_s.bcon[b][CFM_REQ] = 1'b0;
          next_s.bcon[b][CFM_ABT] = 1'b1; // RL14 RL15
          next_s.apend[b]         = 1'b0;
        end
        CFM_TX_LOST: begin
          next_s.bcon[b][CFM_LRB] = 1'b1; // RL16
        end
        CFM_TX_BUSERR: begin
          next_s.bcon[b][CFM_ERR] = 1'b1; // RL17
        end
      endcase
    end

    // Acceptance filtering, lowest filter number wins
    if (rx_frame.valid) begin
      for (int f = CFM_NF - 1; f >= 0; f--) begin
        msel = s.fsel[2*f +: 2];
        if (msel != CFM_MSK_RSVD &&
            cfm_match(filt_id[f], s.msid[msel], s.meid[msel], rx_frame)) begin // RL7
          hit  = 1'b1;
          hitf = 4'(f);
        end
      end
    end
    if (hit) begin
      ptr               = s.bptr[hitf*4 +: 4];
      next_s.hit.valid  = 1'b1;
      next_s.hit.filter = hitf;
      next_s.hit.ptr    = ptr;
      if (ptr == CFM_PTR_FIFO) begin
        next_s.hit.fifo = 1'b1; // RL6
      end else if (ptr < 4'(CFM_NB) && s.bcon[ptr[2:0]][CFM_DIR]) begin // RL12
        if (rx_frame.rtr && s.bcon[ptr[2:0]][CFM_RTR]) begin
          next_s.bcon[ptr[2:0]][CFM_REQ] = 1'b1; // RL19
          next_s.bcon[ptr[2:0]][CFM_ABT:CFM_ERR] = 3'h0; // RL18
          next_s.apend[ptr[2:0]] = 1'b0;
        end
      end else begin
        do_store = 1'b1; // RL6
        sb       = {1'b0, ptr};
      end
    end else if (rx_fifo_wr.valid) begin
      do_store = 1'b1;
      sb       = rx_fifo_wr.buf_num;
    end

    // Hardware set wins over a same-cycle software clear
    if (do_store) begin
      if (s.full[sb]) begin
        next_s.ovf[sb] = 1'b1; // RL10
      end else begin
        next_s.full[sb]  = 1'b1; // RL8
        next_s.hit.store = hit;
      end
    end

    // Transmit selection
    next_s.pick = '0;
    for (int i = CFM_NB - 1; i >= 0; i--) begin
      if (s.bcon[i][CFM_DIR] && s.bcon[i][CFM_REQ] && !s.apend[i] &&
          (!next_s.pick.valid || s.bcon[i][CFM_PRI +: 2] >= bpri)) begin // RL20 RL21
        next_s.pick.valid   = 1'b1;
        next_s.pick.buf_num = 3'(i);
        bpri                = s.bcon[i][CFM_PRI +: 2];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      s <= CFM_ST_RST;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s.bvalid;
  assign s_axi_wready  = s_axi_awvalid && s_axi_wvalid && !s.bvalid;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rresp   = s.rresp;
  assign s_axi_rdata   = s.rdata;
  assign rx_hit        = s.hit;
  assign tx_pick       = s.pick;
  assign tx_abort_pend = s.apend;

endmodule

// ===== cfm_filter_ctrl_assertions.sv
// Concurrent checks on the filter and buffer control ports.
// Assumes binding to every cfm_filter_ctrl instance; one clock domain.
module cfm_filter_ctrl_chk
  import cfm_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic [CFM_AW-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire cfm_frame_t        rx_frame,
  input wire cfm_tx_evt_t       tx_evt,
  input wire cfm_rx_hit_t       rx_hit,
  input wire cfm_tx_pick_t      tx_pick,
  input wire logic [CFM_NB-1:0] tx_abort_pend
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [CFM_NB-1:0] pend_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // Abort flags one cycle back, aligned with the pick
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= '0;
    end else begin
      pend_q <= tx_abort_pend;
    end
  end

  chk_hit_cause: assert property (
    rx_hit.valid |-> $past(rx_frame.valid))
    else $error("filter hit without a received frame");
  chk_hit_fifo: assert property (
    rx_hit.valid |-> (rx_hit.fifo == (rx_hit.ptr == CFM_PTR_FIFO)))
    else $error("fifo steering does not follow the pointer");
  chk_fifo_nostore: assert property (
    rx_hit.valid && rx_hit.fifo |-> !rx_hit.store)
    else $error("fifo hit also stored into a buffer");
  chk_abort_rise: assert property (
    $rose(tx_abort_pend[1]) |->
      $past(s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && s_axi_awaddr == CFM_OFS_BCON))
    else $error("abort pending without a control write");
  chk_abort_end: assert property (
    tx_abort_pend[1] && tx_evt.valid && tx_evt.buf_num == 3'h1 &&
      tx_evt.kind == CFM_TX_ABORTED |=> !tx_abort_pend[1])
    else $error("abort pending kept after abort outcome");
  chk_pick_pend: assert property (
    tx_pick.valid |-> !pend_q[tx_pick.buf_num])
    else $error("picked a buffer with an abort pending");
  chk_b_once: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_r_once: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
endmodule

bind cfm_filter_ctrl cfm_filter_ctrl_chk i_cfm_filter_ctrl_chk (.sys_clk, .rst_n, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready,
  .rx_frame, .tx_evt, .rx_hit, .tx_pick, .tx_abort_pend);

// ===== cfm_can_node.sv
// Far-side model: received frames, fifo stores and transmit outcomes.
// Assumes its tasks are called just after a rising edge of sys_clk.
module cfm_can_node
  import cfm_pkg::*;
(
  input  wire logic sys_clk,
  output cfm_frame_t   rx_frame,
  output cfm_fifo_wr_t rx_fifo_wr,
  output cfm_tx_evt_t  tx_evt
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_frame   = '0;
    rx_fifo_wr = '0;
    tx_evt     = '0;
  end
  // Idle fields flip so stale values never match
  task automatic frame(input logic ide, rtr, input logic [10:0] std_id_bits, input logic [17:0] ext_id_bits);
    rx_frame <= '{1'b1, ide, rtr, std_id_bits, ext_id_bits};
    @(posedge sys_clk);
    rx_frame <= '{1'b0, ~ide, ~rtr, ~std_id_bits, ~ext_id_bits};
  endtask
  task automatic fifo(input logic [4:0] n);
    rx_fifo_wr <= '{1'b1, n};
    @(posedge sys_clk);
    rx_fifo_wr <= '{1'b0, ~n};
  endtask
  task automatic ev(input logic [2:0] b, input cfm_txk_t k);
    tx_evt <= '{1'b1, b, k};
    @(posedge sys_clk);
    tx_evt <= '{1'b0, ~b, k};
  endtask
endmodule

// ===== cfm_filter_ctrl_tb.sv
// Bench: register access, acceptance filtering, receive flags, transmit control.
// Assumes the checker is bound and the node model drives the far-side inputs except filt_id, which the bench sets.
module cfm_filter_ctrl_tb
  import cfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      sys_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic                      s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic                      s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [CFM_AW-1:0]         s_axi_awaddr, s_axi_araddr;
  logic [31:0]               s_axi_wdata, s_axi_rdata;
  logic [3:0]                s_axi_wstrb, rdy;
  logic [1:0]                s_axi_bresp, s_axi_rresp;
  logic [CFM_NB-1:0]         tx_abort_pend;
  cfm_filt_id_t [CFM_NF-1:0] filt_id;
  cfm_frame_t                rx_frame;
  cfm_fifo_wr_t              rx_fifo_wr;
  cfm_tx_evt_t               tx_evt;
  cfm_rx_hit_t               rx_hit;
  cfm_tx_pick_t              tx_pick;
  int                        bad_count, samples_checked;

  assign rdy = {s_axi_rvalid, s_axi_arready, s_axi_bvalid, s_axi_awready};
  always #12.5 sys_clk = ~sys_clk;

  cfm_filter_ctrl i_cfm_filter_ctrl (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .filt_id, .rx_frame, .rx_fifo_wr, .tx_evt,
    .rx_hit, .tx_pick, .tx_abort_pend);
  cfm_can_node i_cfm_can_node (.sys_clk, .rx_frame, .rx_fifo_wr, .tx_evt);

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait for one ready or valid, checked after the edge settles
  task automatic await(input int w);
    int n;
    n = 0;
    #1;
    while (rdy[w] !== 1'b1) begin
      n++;
      if (n > 40) begin
        bad_count++;
        summarize();
      end
      @(posedge sys_clk);
      #1;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r = CFM_OKAY);
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_wstrb   <= 4'h3;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    await(0);
    chk({31'h0, s_axi_wready}, 32'h1);
    @(posedge sys_clk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    await(1);
    chk({30'h0, s_axi_bresp}, {30'h0, r});
    @(posedge sys_clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] r = CFM_OKAY);
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    await(2);
    @(posedge sys_clk);
    s_axi_arvalid <= 1'b0;
    await(3);
    chk(s_axi_rdata, {16'h0000, e});
    chk({30'h0, s_axi_rresp}, {30'h0, r});
    @(posedge sys_clk);
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic [31:0] hv(input logic [3:0] f, p, input logic fi, st);
    return {21'h0, 1'b1, f, p, fi, st};
  endfunction
  // Frame in, then the hit seen one cycle later (zero when none)
  task automatic fr(input logic ide, rtr, input logic [10:0] s, input logic [31:0] e);
    i_cfm_can_node.frame(ide, rtr, s, 18'(s));
    #1;
    chk(rx_hit.valid ? {21'h0, rx_hit} : 32'h0, e);
  endtask

  initial begin
    bad_count = 0;
    samples_checked = 0;
    {sys_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    for (int i = 0; i < CFM_NF; i++) filt_id[i] = '{11'(i), i == 6, 18'(i)};
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    for (int a = 'h18; a < 'h38; a += 4) rd(8'(a), 16'h0000);
    wr(CFM_OFS_BPTR, 16'h3210);
    wr(CFM_OFS_BPTR + 8'h04, 16'h7654);
    wr(CFM_OFS_MSID, 16'hffe0);
    fr(0, 0, 11'd5, hv(4'h5, 4'h5, 0, 1));
    rd(CFM_OFS_FULL, 16'h0020);
    i_cfm_can_node.frame(0, 0, 11'd5, 18'd5);
    #1;
    chk({21'h0, rx_hit}, hv(4'h5, 4'h5, 0, 0));
    rd(CFM_OFS_OVF, 16'h0020);
    wr(CFM_OFS_FULL, 16'hffff);
    rd(CFM_OFS_FULL, 16'h0020);
    wr(CFM_OFS_FULL, 16'h0000);
    wr(CFM_OFS_OVF, 16'h0000);
    rd(CFM_OFS_OVF, 16'h0000);
    wr(CFM_OFS_MSID, 16'hffc0);
    fr(0, 0, 11'd5, hv(4'h4, 4'h4, 0, 1));
    wr(CFM_OFS_MSID, 16'hffe8);
    fr(1, 0, 11'd6, hv(4'h6, 4'h6, 0, 1));
    fr(0, 0, 11'd6, 32'h0);
    fr(1, 0, 11'd7, 32'h0);
    wr(CFM_OFS_MSID, 16'hffe0);
    fr(1, 0, 11'd7, hv(4'h7, 4'h7, 0, 1));
    wr(CFM_OFS_MEID, 16'hffff);
    i_cfm_can_node.frame(1, 0, 11'd6, 18'd7);
    #1;
    chk({31'h0, rx_hit.valid}, 32'h0);
    wr(CFM_OFS_BPTR + 8'h04, 16'h76f4);
    fr(0, 0, 11'd5, hv(4'h5, 4'hf, 1, 0));
    for (int c = 1; c < 4; c++) begin
      wr(CFM_OFS_FSEL, 16'(c << 10));
      fr(0, 0, 11'd5, (c == 3) ? 32'h0 : hv(4'h5, 4'hf, 1, 0));
    end
    wr(CFM_OFS_FSEL, 16'h0000);
    wr(CFM_OFS_BCON + 8'h04, 16'h8480);
    fr(0, 1, 11'd2, hv(4'h2, 4'h2, 0, 0));
    fr(0, 1, 11'd3, hv(4'h3, 4'h3, 0, 0));
    rd(CFM_OFS_BCON + 8'h04, 16'h8c80);
    rd(CFM_OFS_FULL, 16'h00d0);
    wr(CFM_OFS_BCON, 16'h898b);
    repeat (2) @(posedge sys_clk);
    #1;
    chk({28'h0, tx_pick}, 32'h8);
    i_cfm_can_node.ev(3'd0, CFM_TX_LOST);
    rd(CFM_OFS_BCON, 16'h89ab);
    i_cfm_can_node.ev(3'd0, CFM_TX_BUSERR);
    rd(CFM_OFS_BCON, 16'h89bb);
    i_cfm_can_node.ev(3'd0, CFM_TX_SENT);
    rd(CFM_OFS_BCON, 16'h89b3);
    repeat (2) @(posedge sys_clk);
    #1;
    chk({28'h0, tx_pick}, 32'h9);
    wr(CFM_OFS_BCON, 16'h81b3);
    #1;
    chk({24'h0, tx_abort_pend}, 32'h2);
    repeat (2) @(posedge sys_clk);
    #1;
    chk({28'h0, tx_pick}, 32'hb);
    i_cfm_can_node.ev(3'd1, CFM_TX_ABORTED);
    rd(CFM_OFS_BCON, 16'hc1b3);
    wr(CFM_OFS_BCON, 16'h898b);
    rd(CFM_OFS_BCON, 16'h898b);
    wr(CFM_OFS_BCON, 16'h8b8b);
    repeat (2) @(posedge sys_clk);
    #1;
    chk({28'h0, tx_pick}, 32'h8);
    i_cfm_can_node.fifo(5'd20);
    rd(CFM_OFS_FULL + 8'h04, 16'h0010);
    wr(CFM_OFS_MSID + 8'h08, 16'hffff);
    rd(CFM_OFS_MSID + 8'h08, 16'hffeb);
    wr(CFM_OFS_END, 16'hffff, CFM_DECERR);
    rd(CFM_OFS_END, 16'h0000, CFM_DECERR);
    summarize();
  end
endmodule
